/* File: logic/fsw_pkg.sv */
/*
 * constants for the flash status and write-protect block
 * assumes spi mode 0/3 framing, msb first, 8-bit opcodes
 */
package fsw_pkg;
    // status bit positions
    localparam int unsigned BIT_WIP = 0;
    localparam int unsigned BIT_WEL = 1;
    localparam int unsigned BIT_BP_LO = 2;
    localparam int unsigned BIT_QE = 6;
    localparam int unsigned BIT_STATUS_WRITE_DISABLE = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // opcodes
    localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] OP_SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] OP_ABW = 8'h15;
    localparam logic [7:0] OP_SE1 = 8'h20;
    localparam logic [7:0] OP_QPP1 = 8'h32;
    localparam logic [7:0] OP_QPP2 = 8'h38;
    localparam logic [7:0] OP_FRW = 8'h42;
    localparam logic [7:0] OP_FRR = 8'h48;
    localparam logic [7:0] OP_B32 = 8'h52;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_RDERP = 8'h81;
    localparam logic [7:0] OP_IRP = 8'h62;
    localparam logic [7:0] OP_VRP2 = 8'h63;
    localparam logic [7:0] OP_IRE = 8'h64;
    localparam logic [7:0] OP_NVRP = 8'h65;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_NVERP = 8'h85;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_VRP1 = 8'hc0;
    localparam logic [7:0] OP_CE1 = 8'hc7;
    localparam logic [7:0] OP_SE2 = 8'hd7;
    localparam logic [7:0] OP_B64 = 8'hd8;
    // default busy time of a write operation, in system cycles
    localparam int unsigned BUSY_CYCLES = 64;
    typedef enum logic [1:0] {
        FSW_IDLE = 2'b00,
        FSW_OPC = 2'b01,
        FSW_ARG = 2'b11,
        FSW_DONE = 2'b10
    } fsw_phase_t;
endpackage

/* File: logic/fsw_status_wp.sv */
/*
 * status register, write-enable latch and write protection of a serial
 * flash, reached over spi (mode 0, msb first) from an external host.
 * assumes: sck, cs_n, mosi and the shared pins are asynchronous pins,
 * sampled by ref_clk_in; sck is far slower than ref_clk_in.
 */
// Behaviour
// RL1: repeated read resends status until deselect
// RL2: status bits laid out status_write_disable..wip, zero default
// RL3: wip set during writes, clears when done
// RL4: busy ignores all but reads, reset, suspend
// RL5: wel low blocks enabled write operations
// RL6: set latch command sets wel
// RL7: clear command or write completion clears wel
// RL8: status write leaves wel untouched
// RL9: host enables before program and erase
// RL10: host enables before nonvolatile writes
// RL11: volatile parameter writes need no wel
// RL12: status write loads bp, qe, status_write_disable
// RL13: status read returns live status
// RL14: protected blocks refuse program and erase
// RL15: chip erase only with all bp zero
// RL16: status_write_disable with wp low locks status
// RL17: otherwise status write may change status
// RL18: qe selects wp/hold or quad data pins
// RL19: host keeps qe low with tied pins
// RL20: bp code maps to top/bottom 64k blocks
// RL21: qe or quad mode ignores hold/reset select
// RL22: polled status shows wip live
`timescale 1ns/1ps
`default_nettype none
module fsw_status_wp #(
    parameter int unsigned BUSY_LEN = fsw_pkg::BUSY_CYCLES,
    parameter int unsigned NBLK = 16 // 64k blocks in the array
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic sck_in, // spi clock from host
    input wire logic cs_n_in, // chip select, active low
    input wire logic mosi_in, // host data in
    input wire logic wp_io2_in, // shared write-protect / data 2 pin
    input wire logic hold_io3_in, // shared hold / data 3 pin
    input wire logic hold_sel_in, // hold vs reset select from read reg
    input wire logic quad_mode_in, // quad-command mode active
    output logic miso_out,
    output logic miso_oe_out,
    output logic [7:0] status_out,
    output logic write_protect_n_out, // pin function when qe low
    output logic hold_n_out,
    output logic reset_n_out,
    output logic quad_pins_out // shared pins act as data lines
);
    // ********************************************************
    // elaboration check
    // ********************************************************
    if (BUSY_LEN < 1 || BUSY_LEN > 65535 || NBLK != 16) begin : g_chk
        $error("fsw_status_wp: unsupported parameter");
    end
    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic [1:0] sck_s; // two-flop sync, bit 0 first stage
        logic [1:0] cs_s;
        logic [1:0] mo_s;
        logic [1:0] wp_s;
        logic [1:0] ho_s;
        logic sck_d; // edge detect on synced clock
        fsw_pkg::fsw_phase_t ph;
        logic [7:0] opc; // opcode once received
        logic [7:0] sh; // input shifter
        logic [5:0] nbit; // bits in this frame
        logic [7:0] tx; // output shifter
        logic [2:0] txc;
        logic [7:0] arg; // first data byte
        logic [23:0] addr;
        logic status_write_disable, qe, write_enable_latch, write_in_progress;
        logic [3:0] bp;
        logic [15:0] busy_cnt;
        logic miso, oe;
    } fsw_state_t;
    fsw_state_t s_reg, s_next;
    logic sck_rise, sck_fall, cs_act, cs_end;
    logic [7:0] stat; // live status word
    logic needs_wel, is_prog, is_ce, allowed_busy, prot_hit;
    logic [3:0] blk;
    // ********************************************************
    // decode helpers
    // ********************************************************
    // protected area of a 4-bit code for a 16-block array
    function automatic logic blk_protected(input logic [3:0] code,
                                           input logic [3:0] b);
        logic [4:0] n;
        n = 5'h00;
        // RL20: top or bottom table
        if (code == 4'h0 || code == 4'hf) begin
            return 1'b0;
        end else if (!code[3]) begin
            // 1,2,4,8 top blocks, more codes mean all
            n = (code[2:0] > 3'h4) ? 5'h10 : 5'(5'h01 << (code[2:0] - 3'h1));
            return ({1'b0, b} >= 5'(5'h10 - n));
        end else begin
            n = (code[2:0] < 3'h3) ? 5'h10 : 5'(5'h08 >> (code[2:0] - 3'h3));
            return ({1'b0, b} < n);
        end
    endfunction
    // ********************************************************
    // next-state logic
    // ********************************************************
    always_comb begin
        s_next = s_reg;
        // pins pass two flops before any logic reads them
        s_next.sck_s = {s_reg.sck_s[0], sck_in};
        s_next.cs_s = {s_reg.cs_s[0], cs_n_in};
        s_next.mo_s = {s_reg.mo_s[0], mosi_in};
        s_next.wp_s = {s_reg.wp_s[0], wp_io2_in};
        s_next.ho_s = {s_reg.ho_s[0], hold_io3_in};
        s_next.sck_d = s_reg.sck_s[1];
        sck_rise = s_reg.sck_s[1] && !s_reg.sck_d;
        sck_fall = !s_reg.sck_s[1] && s_reg.sck_d;
        cs_act = !s_reg.cs_s[1];
        cs_end = s_reg.cs_s[1] && (s_reg.ph != fsw_pkg::FSW_IDLE);
        // RL2: status layout
        // RL13: read returns register state
        // RL22: wip is the live busy bit
        stat = {s_reg.status_write_disable, s_reg.qe, s_reg.bp, s_reg.write_enable_latch, s_reg.write_in_progress};
        // RL5: classes needing the latch
        // RL11: volatile parameter sets absent here
        needs_wel = 1'b0;
        is_prog = 1'b0;
        is_ce = 1'b0;
        case (s_reg.opc)
            fsw_pkg::OP_PP, fsw_pkg::OP_QPP1, fsw_pkg::OP_QPP2,
            fsw_pkg::OP_SE1, fsw_pkg::OP_SE2, fsw_pkg::OP_B32,
            fsw_pkg::OP_B64: begin
                needs_wel = 1'b1;
                is_prog = 1'b1;
            end
            fsw_pkg::OP_CE1, fsw_pkg::OP_CE2: begin
                needs_wel = 1'b1;
                is_ce = 1'b1;
            end
            fsw_pkg::OP_STATUS_WRITE_CMD, fsw_pkg::OP_FRW, fsw_pkg::OP_NVRP,
            fsw_pkg::OP_NVERP, fsw_pkg::OP_IRE, fsw_pkg::OP_IRP,
            fsw_pkg::OP_ABW: begin
                needs_wel = 1'b1;
            end
            default: begin
                needs_wel = 1'b0;
            end
        endcase
        // RL4: what a busy device still takes
        allowed_busy = (s_reg.sh == fsw_pkg::OP_STATUS_READ_CMD) ||
                       (s_reg.sh == fsw_pkg::OP_FRR) ||
                       (s_reg.sh == fsw_pkg::OP_RDERP) ||
                       (s_reg.sh == fsw_pkg::OP_RSTEN) ||
                       (s_reg.sh == fsw_pkg::OP_RST) ||
                       (s_reg.sh == fsw_pkg::OP_SUSP);
        // 1 Mbyte array: block number from address bits 19:16
        blk = s_reg.addr[19:16];
        // RL14: protected target
        prot_hit = blk_protected(s_reg.bp, blk);
        // busy timer; completion clears wip and wel
        if (s_reg.write_in_progress) begin
            if (s_reg.busy_cnt == 16'h0001) begin
                // RL3: done regardless of outcome
                s_next.write_in_progress = 1'b0;
                // RL7: latch drops on completion
                s_next.write_enable_latch = 1'b0;
            end
            s_next.busy_cnt = 16'(s_reg.busy_cnt - 16'h0001);
        end
        // serial front end
        if (!cs_act) begin
            // deselect ends frame, then executes the write
            s_next.oe = 1'b0;
            s_next.ph = fsw_pkg::FSW_IDLE;
            if (cs_end && s_reg.ph == fsw_pkg::FSW_ARG &&
                !s_reg.write_in_progress && s_reg.write_enable_latch && needs_wel) begin
                if (s_reg.opc == fsw_pkg::OP_STATUS_WRITE_CMD &&
                    s_reg.nbit >= 6'd16) begin
                    // RL16: hardware lock ignores the write
                    // RL17: unlocked write applies
                    if (!(s_reg.status_write_disable && !s_reg.wp_s[1])) begin
                        // RL12: nonvolatile fields only
                        // RL8: wel not touched here
                        s_next.status_write_disable = s_reg.arg[fsw_pkg::BIT_STATUS_WRITE_DISABLE];
                        s_next.qe = s_reg.arg[fsw_pkg::BIT_QE];
                        s_next.bp = s_reg.arg[fsw_pkg::BIT_BP_LO +: 4];
                        s_next.write_in_progress = 1'b1;
                        s_next.busy_cnt = 16'(BUSY_LEN);
                    end
                end else if (is_ce) begin
                    // RL15: chip erase needs all bp clear
                    if (s_reg.bp == 4'h0) begin
                        s_next.write_in_progress = 1'b1;
                        s_next.busy_cnt = 16'(BUSY_LEN);
                    end
                end else if (is_prog) begin
                    // RL14: inhibit inside protected area
                    if (s_reg.nbit >= 6'd32 && !prot_hit) begin
                        s_next.write_in_progress = 1'b1;
                        s_next.busy_cnt = 16'(BUSY_LEN);
                    end
                end else if (s_reg.opc != fsw_pkg::OP_STATUS_WRITE_CMD &&
                             s_reg.nbit >= 6'd16) begin
                    // other nonvolatile writes: just busy
                    s_next.write_in_progress = 1'b1;
                    s_next.busy_cnt = 16'(BUSY_LEN);
                end
            end
        end else begin
            if (s_reg.ph == fsw_pkg::FSW_IDLE) begin
                s_next.ph = fsw_pkg::FSW_OPC;
                s_next.nbit = 6'd0;
                s_next.txc = 3'd0;
            end
            if (sck_rise && s_reg.ph != fsw_pkg::FSW_DONE) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.mo_s[1]};
                if (s_reg.nbit != 6'h3f) begin
                    s_next.nbit = 6'(s_reg.nbit + 6'd1);
                end
                if (s_reg.ph == fsw_pkg::FSW_ARG) begin
                    s_next.addr = {s_reg.addr[22:0], s_reg.mo_s[1]};
                    if (s_reg.nbit == 6'd15) begin
                        s_next.arg = {s_reg.sh[6:0], s_reg.mo_s[1]};
                    end
                end
            end
            // opcode complete: act on it
            if (s_reg.ph == fsw_pkg::FSW_OPC && s_reg.nbit == 6'd8) begin
                s_next.opc = s_reg.sh;
                s_next.ph = fsw_pkg::FSW_ARG;
                s_next.addr = 24'h000000;
                // RL4: busy ignores the rest
                if (s_reg.write_in_progress && !allowed_busy) begin
                    s_next.ph = fsw_pkg::FSW_DONE;
                end else if (s_reg.sh == fsw_pkg::OP_SET_WRITE_LATCH_CMD) begin
                    // RL6: set latch
                    s_next.write_enable_latch = 1'b1;
                end else if (s_reg.sh == fsw_pkg::OP_CLEAR_WRITE_LATCH_CMD) begin
                    // RL7: clear latch
                    s_next.write_enable_latch = 1'b0;
                end else if (s_reg.sh == fsw_pkg::OP_STATUS_READ_CMD) begin
                    s_next.tx = stat;
                    s_next.oe = 1'b1;
                end
            end
            // RL1: status resent until deselect
            if (s_reg.oe && sck_fall) begin
                s_next.miso = s_reg.tx[3'd7 - s_reg.txc];
                s_next.txc = 3'(s_reg.txc + 3'd1);
                if (s_reg.txc == 3'd7) begin
                    // RL22: reload the live value each byte
                    s_next.tx = stat;
                end
            end
        end
    end
    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_reg <= '0;
            s_reg.sck_s <= 2'b00;
            s_reg.cs_s <= 2'b11;
            s_reg.wp_s <= 2'b11;
            s_reg.ho_s <= 2'b11;
            s_reg.ph <= fsw_pkg::FSW_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end
    // ********************************************************
    // outputs, all registered
    // ********************************************************
    // pin functions follow qe; hold/reset select dropped under quad
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
            status_out <= fsw_pkg::STATUS_RESET;
            write_protect_n_out <= 1'b1;
            hold_n_out <= 1'b1;
            reset_n_out <= 1'b1;
            quad_pins_out <= 1'b0;
        end else begin
            miso_out <= s_reg.miso;
            miso_oe_out <= s_reg.oe;
            status_out <= {s_reg.status_write_disable, s_reg.qe, s_reg.bp,
                           s_reg.write_enable_latch, s_reg.write_in_progress};
            // RL18: shared pin roles
            quad_pins_out <= s_reg.qe;
            write_protect_n_out <= s_reg.qe | s_reg.wp_s[1];
            // RL21: select ignored in quad use
            hold_n_out <= (s_reg.qe || quad_mode_in || hold_sel_in) ?
                          1'b1 : s_reg.ho_s[1];
            reset_n_out <= (s_reg.qe || quad_mode_in || !hold_sel_in) ?
                           1'b1 : s_reg.ho_s[1];
        end
    end
    // ********************************************************
    // checks
    // ********************************************************
    wel_set_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL6
        (cs_act && s_reg.ph == fsw_pkg::FSW_OPC && s_reg.nbit == 6'd8 &&
         s_reg.sh == fsw_pkg::OP_SET_WRITE_LATCH_CMD && !s_reg.write_in_progress) |=> s_reg.write_enable_latch)
        else $error("latch not set by enable");
    wip_done_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL3
        (s_reg.write_in_progress && s_reg.busy_cnt == 16'h0001) |=> !s_reg.write_in_progress && !s_reg.write_enable_latch)
        else $error("busy did not finish");
    lock_hold_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL16
        (s_reg.status_write_disable && !s_reg.wp_s[1]) |=> $stable(s_reg.bp) && $stable(s_reg.qe))
        else $error("locked status changed");
    busy_ign_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL4
        (s_reg.write_in_progress && s_reg.busy_cnt > 16'h0001) |=> $stable(s_reg.write_enable_latch))
        else $error("latch moved while busy");
    nowel_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL5
        (!s_reg.write_enable_latch && !s_reg.write_in_progress) |=> !s_reg.write_in_progress)
        else $error("write started without latch");
    ce_prot_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL15
        (!s_reg.write_in_progress && s_reg.bp != 4'h0 && cs_end && is_ce) |=> !s_reg.write_in_progress)
        else $error("chip erase not blocked");
    qe_pin_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL18
        s_reg.qe |=> quad_pins_out && write_protect_n_out)
        else $error("pin role wrong");
    stat_out_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RL2
        ##1 status_out == $past(stat))
        else $error("status word mismatch");
endmodule
`default_nettype wire

/* File: verification/fsw_host_model.sv */
/* spi host model: mode 0 master that frames opcodes for the status block
   assumes the bench clock; one serial period is 8 ref clocks (400 ns) */
`timescale 1ns/1ps
`default_nettype none
module fsw_host_model (
    input wire logic ref_clk_in,
    input wire logic miso_in,
    input wire logic miso_oe_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic mosi_out
);
    // ****************************************
    // serial frames
    // ****************************************
    // idle: deselected, clock parked low between frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // enable before writes
    // the bench sends the set latch frame ahead; this task only frames
    // one frame, msb first; a released data line reads as unknown
    task automatic frame(input logic [31:0] tx, input int nb,
            output logic [31:0] rx);
        rx = '0;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        for (int i = nb - 1; i >= 0; i--) begin
            mosi_out <= tx[i];
            // low half of 5 clocks: the block needs 4 to show a new bit
            repeat (4) @(posedge ref_clk_in);
            // sample half a ref clock before the rise, never at it
            @(negedge ref_clk_in);
            rx[i] = miso_oe_in ? miso_in : 1'bx;
            @(posedge ref_clk_in);
            sck_out <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            sck_out <= 1'b0;
        end
        repeat (4) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        // released line flips so a stale level is never trusted
        mosi_out <= ~mosi_out;
        repeat (8) @(posedge ref_clk_in);
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
/* self-checking bench for the flash status and write-protect block
   assumes fsw_pkg and the host model are compiled before it */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
    // ****************************************
    // clock, pins and instances
    // ****************************************
    logic clk = 1'b0; // 20 mhz system clock
    logic srst = 1'b1;
    logic wp = 1'b1; // shared pins idle high, as a pull-up leaves them
    logic hold = 1'b1;
    logic hold_sel = 1'b0;
    logic quad_mode = 1'b0; // quad-command mode left off
    wire sck, cs_n, mosi, miso, miso_oe, wp_n, hold_n, rst_n, quad;
    wire [7:0] st; // live status from the block
    logic [31:0] rx; // last frame's returned bits
    int bad_count = 0;
    int checks = 0;
    // opcodes that all need the latch set first
    logic [7:0] wr_ops [16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20,
        8'h52, 8'hd8, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64,
        8'h62, 8'h15};
    always #25 clk = ~clk;
    // busy lengthened so a frame still fits inside it
    fsw_status_wp #(.BUSY_LEN(600)) dut_u (.ref_clk_in(clk),
        .srst_in(srst), .sck_in(sck), .cs_n_in(cs_n), .mosi_in(mosi),
        .wp_io2_in(wp), .hold_io3_in(hold), .hold_sel_in(hold_sel),
        .quad_mode_in(quad_mode), .miso_out(miso), .miso_oe_out(miso_oe),
        .status_out(st), .write_protect_n_out(wp_n), .hold_n_out(hold_n),
        .reset_n_out(rst_n), .quad_pins_out(quad));
    fsw_host_model host_u (.ref_clk_in(clk), .miso_in(miso),
        .miso_oe_in(miso_oe), .sck_out(sck), .cs_n_out(cs_n),
        .mosi_out(mosi));
    // ****************************************
    // helpers
    // ****************************************
    // frame, then settle half a clock before anyone looks
    task automatic xfer(input logic [31:0] tx, input int nb);
        host_u.frame(tx, nb, rx);
        @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        xfer({24'h0, op}, 8);
    endtask
    task automatic wr_st(input logic [7:0] d);
        xfer({16'h0, fsw_pkg::OP_STATUS_WRITE_CMD, d}, 16);
    endtask
    // bounded poll; a hung busy flag shows as a mismatch
    task automatic wait_idle();
        int n;
        n = 0;
        while (st[0] !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK(st[0], 1'b0)
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        `CHK(st, fsw_pkg::STATUS_RESET)
        `CHK({wp_n, hold_n, rst_n, quad}, 4'b1110)
    endtask
    // latch set, streamed twice in one selection, then cleared
    task automatic t_latch();
        cmd(8'h06);
        `CHK(st, 8'h02)
        xfer({8'h0, 8'h05, 16'h0}, 24);
        `CHK(rx[15:0], 16'h0202)
        cmd(8'h04);
        `CHK(st, 8'h00)
    endtask
    // refused without latch; busy ignores clear; poll shows busy
    task automatic t_busy();
        wr_st(8'h3c);
        `CHK(st, 8'h00)
        cmd(8'h06);
        wr_st(8'h04);
        `CHK(st[1:0], 2'b11)
        cmd(8'h04);
        `CHK(st[1], 1'b1)
        xfer({16'h0, 8'h05, 8'h0}, 16);
        `CHK(rx[7:0], 8'h07)
        wait_idle();
        `CHK(st, 8'h04)
    endtask
    // code 0001 guards the top block only
    task automatic t_protect();
        cmd(8'h06);
        xfer({8'h02, 24'h0f0000}, 32);
        `CHK(st, 8'h06)
        cmd(8'hc7);
        `CHK(st, 8'h06)
        cmd(8'h60);
        `CHK(st, 8'h06)
        xfer({8'h02, 24'h000000}, 32);
        `CHK(st[0], 1'b1)
        wait_idle();
        cmd(8'h06);
        wr_st(8'h00);
        wait_idle();
        `CHK(st, 8'h00)
    endtask
    // every write-class opcode: refused, then accepted once enabled
    task automatic t_wel_ops();
        foreach (wr_ops[i]) begin
            xfer({wr_ops[i], 24'h0}, 32);
            `CHK(st[0], 1'b0)
            cmd(8'h06);
            xfer({wr_ops[i], 24'h0}, 32);
            `CHK(st[0], 1'b1)
            wait_idle();
            `CHK(st, 8'h00)
        end
    endtask
    // disable bit locks status only while the protect pin is low
    task automatic t_lock();
        cmd(8'h06);
        wr_st(8'h80);
        wait_idle();
        wp <= 1'b0;
        cmd(8'h06);
        wr_st(8'h84);
        `CHK(st, 8'h82)
        wp <= 1'b1;
        wr_st(8'h84);
        wait_idle();
        `CHK(st, 8'h84)
        cmd(8'h06);
        wr_st(8'h00);
        wait_idle();
    endtask
    // pin functions with quad off, then swallowed with quad on
    task automatic t_pins();
        wp <= 1'b0;
        hold <= 1'b0;
        repeat (8) @(negedge clk);
        `CHK({wp_n, hold_n, rst_n}, 3'b001)
        hold_sel <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK({hold_n, rst_n}, 2'b10)
        wp <= 1'b1;
        hold <= 1'b1;
        repeat (16) @(negedge clk);
        cmd(8'h06);
        wr_st(8'h40);
        wait_idle();
        `CHK(st, 8'h40)
        wp <= 1'b0;
        hold <= 1'b0;
        repeat (8) @(negedge clk);
        `CHK({wp_n, hold_n, rst_n, quad}, 4'b1111)
    endtask
    // ****************************************
    // run control
    // ****************************************
    task automatic end_sim();
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // about 27k cycles expected; allow a wide margin
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        t_reset();
        t_latch();
        t_busy();
        t_protect();
        t_wel_ops();
        t_lock();
        t_pins();
        end_sim();
    end
endmodule
`default_nettype wire
